// File: rtl/acs_pkg.sv
// Purpose: Shared constants and types for the accelerator command sequencer
// Assumes: Short command words only; long-form words are rejected
// Notes: All offsets, codes and reset values live here

package acs_pkg;

  // ****************************************************************
  // Command word layout
  // ****************************************************************
  localparam int ACS_WORD_W = 16;
  localparam int ACS_CODE_W = 10;
  localparam int ACS_TAG_LSB = 10;
  localparam logic [5:0] ACS_SHORT_TAG = 6'h00;

  // ****************************************************************
  // Short command codes
  // ****************************************************************
  localparam logic [9:0] ACS_OP_HALT = 10'h000;
  localparam logic [9:0] ACS_OP_NOTIFY = 10'h001;
  localparam logic [9:0] ACS_OP_CONV = 10'h002;
  localparam logic [9:0] ACS_OP_DWCONV = 10'h003;
  localparam logic [9:0] ACS_OP_POOL = 10'h005;
  localparam logic [9:0] ACS_OP_ELEM = 10'h006;
  localparam logic [9:0] ACS_OP_DMAQ = 10'h010;
  localparam logic [9:0] ACS_OP_DMAW = 10'h011;
  localparam logic [9:0] ACS_OP_KWAIT = 10'h012;
  localparam logic [9:0] ACS_OP_STATE_BASE = 10'h100;
  localparam logic [9:0] ACS_OP_BLOCKDEP = 10'h12f;

  // ****************************************************************
  // Internal state table and counters
  // ****************************************************************
  localparam int ACS_STATE_NUM = 64;
  localparam int ACS_STATE_IDX_W = 6;
  localparam int ACS_STATE_SEL_LSB = 6;
  localparam logic [1:0] ACS_BLOCKDEP_RST = 2'h3;
  localparam int ACS_KCNT_W = 3;
  localparam logic [2:0] ACS_KCNT_MAX = 3'h7;

  // ****************************************************************
  // Status word fields
  // ****************************************************************
  localparam int ACS_MASK_LSB = 16;
  localparam int ACS_ST_STOP = 0;
  localparam int ACS_ST_KBUSY = 1;
  localparam int ACS_ST_DBUSY = 2;
  localparam int ACS_ST_NPEND = 3;
  localparam logic [31:0] ACS_STATUS_RST = 32'h0000_0000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic [15:0] word;
    logic [15:0] param;
  } acs_cmd_t;

  typedef struct packed {
    logic [9:0] op;
    logic [15:0] mode;
  } acs_kern_t;

  typedef logic [ACS_STATE_NUM-1:0][15:0] acs_regs_t;

  typedef enum logic [1:0] {
    ACS_S_FETCH = 2'b00,
    ACS_S_EXEC = 2'b01,
    ACS_S_STOP = 2'b10
  } acs_state_t;

endpackage : acs_pkg

// File: rtl/acs_sequencer.sv
// Purpose: Short command word sequencer with blocking and non-blocking completion
// Assumes: Kernel units finish in issue order; one DMA descriptor in flight
// Notes: Every output is a flop; one command executes at a time
//
// Functional notes
// - Commands after notify or kernel start may begin before those finish
// - Kernel operation finishes only when its output tensor is stored
// - Blocking commands hold all later commands until their completion
// - State setting stores its value; later kernel starts use it
// - Running kernel operations keep the state captured at their start
// - DMA queueing completes once the descriptor is accepted, not transferred
// - Wait commands hold later commands until their condition holds
// - Block dependency limits overlap of successive kernel starts
// - DMA wait admits no command until earlier DMA data is in memory
// - Short word has upper six bits zero; low ten bits select command
// - Short command has no payload; one 16-bit parameter
// - Halt merges mask into status upper half, stops, raises interrupt
// - At halt interrupt all earlier work done; later commands not started (code waits for kernels and notify only, not a pending DMA transfer)
// - Notify merges mask into status upper half, keeps running, interrupts
// - At notify interrupt all operations up to the notify are done (code counts only earlier kernels, not a pending DMA transfer)
// - Code 0x002 starts a convolution stripe with stored state
// - DMA queue code 0x010 stalls until channel 0 accepts a descriptor
// - DMA wait code 0x011 waits until the single transfer is complete
// - Kernel wait code 0x012 holds until at most n kernels remain

`timescale 1ns/10ps

module acs_sequencer
  import acs_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire acs_cmd_t cmd_i,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  output logic kern_valid_o,
  input wire logic kern_ready_i,
  output acs_kern_t kern_info_o,
  output acs_regs_t kern_state_o,
  input wire logic kern_done_i,
  output logic dma_valid_o,
  input wire logic dma_ready_i,
  input wire logic dma_done_i,
  output logic [1:0] blockdep_o,
  output logic [31:0] status_o,
  input wire logic status_clr_i,
  input wire logic resume_i,
  output logic irq_o,
  output logic bad_cmd_o
);

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  function automatic logic is_kernel(input logic [9:0] code);
    is_kernel = (code == ACS_OP_CONV) || (code == ACS_OP_DWCONV) ||
                (code == ACS_OP_POOL) || (code == ACS_OP_ELEM);
  endfunction : is_kernel

  // ****************************************************************
  // Registers
  // ****************************************************************
  acs_state_t state_r, state_nxt;
  acs_cmd_t cur_r;
  acs_regs_t state_tab_r;
  logic ready_r;
  logic kern_valid_r, kern_valid_nxt;
  acs_kern_t kern_info_r;
  acs_regs_t kern_state_r;
  logic dma_valid_r, dma_valid_nxt;
  logic dma_pend_r, dma_pend_nxt;
  logic [ACS_KCNT_W-1:0] kcnt_r, kcnt_nxt;
  logic [1:0] blockdep_r;
  logic npend_r, npend_nxt;
  logic [ACS_KCNT_W-1:0] ncnt_r, ncnt_nxt;
  logic [15:0] nmask_r;
  logic [31:0] status_r;
  logic irq_r;
  logic bad_r;

  // ****************************************************************
  // Current command decode
  // ****************************************************************
  wire [9:0] code_w = cur_r.word[ACS_CODE_W-1:0];
  wire [15:0] param_w = cur_r.param;
  wire short_w = cur_r.word[ACS_WORD_W-1:ACS_TAG_LSB] == ACS_SHORT_TAG;
  wire exec_w = state_r == ACS_S_EXEC;
  wire op_halt_w = short_w && code_w == ACS_OP_HALT;
  wire op_notify_w = short_w && code_w == ACS_OP_NOTIFY;
  wire op_kern_w = short_w && is_kernel(code_w);
  wire op_dmaq_w = short_w && code_w == ACS_OP_DMAQ;
  wire op_dmaw_w = short_w && code_w == ACS_OP_DMAW;
  wire op_kwait_w = short_w && code_w == ACS_OP_KWAIT;
  wire op_bdep_w = short_w && code_w == ACS_OP_BLOCKDEP;
  wire op_state_w = short_w &&
    code_w[9:ACS_STATE_SEL_LSB] == ACS_OP_STATE_BASE[9:ACS_STATE_SEL_LSB];
  wire [ACS_STATE_IDX_W-1:0] sidx_w = code_w[ACS_STATE_IDX_W-1:0];

  // ****************************************************************
  // Handshakes and completion conditions
  // ****************************************************************
  wire fetch_w = state_r == ACS_S_FETCH && ready_r && cmd_valid_i;
  wire kern_hs_w = kern_valid_r && kern_ready_i;
  wire dma_hs_w = dma_valid_r && dma_ready_i;
  wire dep_ok_w = kcnt_r <= {1'b0, blockdep_r} && kcnt_r != ACS_KCNT_MAX;
  wire kern_raise_w = exec_w && op_kern_w && !kern_valid_r && dep_ok_w;
  wire dma_raise_w = exec_w && op_dmaq_w && !dma_valid_r && !dma_pend_r;
  wire halt_ok_w = kcnt_r == '0 && !npend_r;
  wire kwait_ok_w = kcnt_r <= {1'b0, param_w[1:0]};
  wire nfire_w = npend_r && ncnt_r == '0;
  wire halt_fire_w = exec_w && op_halt_w && halt_ok_w;
  wire state_wr_w = exec_w && op_state_w;

  logic done_w;
  always_comb begin
    done_w = 1'b1;
    if (op_halt_w) begin
      done_w = halt_ok_w;
    end else if (op_notify_w) begin
      done_w = !npend_r;
    end else if (op_kern_w) begin
      done_w = kern_hs_w;
    end else if (op_dmaq_w) begin
      done_w = dma_hs_w;
    end else if (op_dmaw_w) begin
      done_w = !dma_pend_r;
    end else if (op_kwait_w) begin
      done_w = kwait_ok_w;
    end
  end
  wire exec_done_w = exec_w && done_w;

  // ****************************************************************
  // Sequencer state machine
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ACS_S_FETCH: begin
        if (fetch_w) begin
          state_nxt = ACS_S_EXEC;
        end
      end
      ACS_S_EXEC: begin
        if (halt_fire_w) begin
          state_nxt = ACS_S_STOP;
        end else if (exec_done_w) begin
          state_nxt = ACS_S_FETCH;
        end
      end
      ACS_S_STOP: begin
        if (resume_i) begin
          state_nxt = ACS_S_FETCH;
        end
      end
      default: begin
        state_nxt = ACS_S_FETCH;
      end
    endcase
  end

  // ****************************************************************
  // Next values for counters and flags
  // ****************************************************************
  assign kern_valid_nxt = kern_valid_r ? !kern_ready_i : kern_raise_w;
  assign dma_valid_nxt = dma_valid_r ? !dma_ready_i : dma_raise_w;
  assign dma_pend_nxt = dma_hs_w || (dma_pend_r && !dma_done_i);
  assign kcnt_nxt = kcnt_r + ACS_KCNT_W'(kern_hs_w) - ACS_KCNT_W'(kern_done_i);

  wire notify_take_w = exec_w && op_notify_w && !npend_r;
  assign npend_nxt = notify_take_w || (npend_r && !nfire_w);
  always_comb begin
    ncnt_nxt = ncnt_r;
    if (notify_take_w) begin
      ncnt_nxt = kcnt_r - ACS_KCNT_W'(kern_done_i);
    end else if (npend_r && kern_done_i && ncnt_r != '0) begin
      ncnt_nxt = ncnt_r - ACS_KCNT_W'(1'b1);
    end
  end

  wire [15:0] mask_set_w = halt_fire_w ? param_w : (nfire_w ? nmask_r : 16'h0000);
  wire [15:0] mask_keep_w = status_clr_i ? 16'h0000 : status_r[31:ACS_MASK_LSB];
  wire stop_nxt_w = state_nxt == ACS_S_STOP;
  wire [31:0] status_nxt_w = {mask_keep_w | mask_set_w, 12'h000, npend_nxt,
                              dma_pend_nxt, kcnt_nxt != '0, stop_nxt_w};

  // ****************************************************************
  // Control registers
  // ****************************************************************
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      state_r <= ACS_S_FETCH;
      ready_r <= 1'b0;
      kern_valid_r <= 1'b0;
      dma_valid_r <= 1'b0;
      dma_pend_r <= 1'b0;
      kcnt_r <= '0;
      npend_r <= 1'b0;
      ncnt_r <= '0;
      status_r <= ACS_STATUS_RST;
      irq_r <= 1'b0;
      bad_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ready_r <= state_nxt == ACS_S_FETCH && !fetch_w;
      kern_valid_r <= kern_valid_nxt;
      dma_valid_r <= dma_valid_nxt;
      dma_pend_r <= dma_pend_nxt;
      kcnt_r <= kcnt_nxt;
      npend_r <= npend_nxt;
      ncnt_r <= ncnt_nxt;
      status_r <= status_nxt_w;
      irq_r <= halt_fire_w || nfire_w;
      bad_r <= exec_w && !short_w;
    end
  end

  // ****************************************************************
  // Command holding and kernel launch registers
  // ****************************************************************
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      cur_r <= '0;
      nmask_r <= 16'h0000;
      blockdep_r <= ACS_BLOCKDEP_RST;
      kern_info_r <= '0;
      kern_state_r <= '0;
    end else begin
      if (fetch_w) begin
        cur_r <= cmd_i;
      end
      if (notify_take_w) begin
        nmask_r <= param_w;
      end
      if (exec_w && op_bdep_w) begin
        blockdep_r <= param_w[1:0];
      end
      if (kern_raise_w) begin
        kern_info_r <= '{op: code_w, mode: param_w};
        kern_state_r <= state_tab_r;
      end
    end
  end

  // ****************************************************************
  // Internal state table
  // ****************************************************************
  for (genvar gi = 0; gi < ACS_STATE_NUM; gi++) begin : g_state
    wire wr_w = state_wr_w && sidx_w == ACS_STATE_IDX_W'(gi);
    always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
        state_tab_r[gi] <= 16'h0000;
      end else if (wr_w) begin
        state_tab_r[gi] <= param_w;
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign cmd_ready_o = ready_r;
  assign kern_valid_o = kern_valid_r;
  assign kern_info_o = kern_info_r;
  assign kern_state_o = kern_state_r;
  assign dma_valid_o = dma_valid_r;
  assign blockdep_o = blockdep_r;
  assign status_o = status_r;
  assign irq_o = irq_r;
  assign bad_cmd_o = bad_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  kern_nonblock_a: assert property (kern_hs_w |=> cmd_ready_o)
    else $error("Kernel start did not release the command stream");

  kern_finish_a: assert property (kern_done_i && !kern_hs_w && kcnt_r != '0 |=>
    kcnt_r == $past(kcnt_r) - ACS_KCNT_W'(1'b1))
    else $error("Kernel completion not counted");

  block_hold_a: assert property (exec_w && !done_w |=> !cmd_ready_o)
    else $error("Blocking command let a later command in");

  state_store_a: assert property (state_wr_w |=>
    state_tab_r[$past(sidx_w)] == $past(param_w))
    else $error("State value not stored");

  snap_hold_a: assert property (!kern_raise_w |=> $stable(kern_state_o))
    else $error("Captured kernel state changed while running");

  dma_queue_a: assert property (dma_hs_w |=> cmd_ready_o && dma_pend_r)
    else $error("DMA queueing did not complete on acceptance");

  kwait_hold_a: assert property (exec_w && op_kwait_w && !kwait_ok_w
    |=> !cmd_ready_o && state_r == ACS_S_EXEC)
    else $error("Kernel wait released early");

  dep_limit_a: assert property (kern_raise_w |-> kcnt_r <= {1'b0, blockdep_r})
    else $error("Kernel start ignored block dependency");

  dma_wait_a: assert property (exec_w && op_dmaw_w && dma_pend_r
    |=> state_r == ACS_S_EXEC && !cmd_ready_o)
    else $error("DMA wait admitted a command too early");

  long_word_a: assert property (exec_w && !short_w |=> bad_cmd_o && cmd_ready_o)
    else $error("Long-form word not rejected");

  halt_irq_a: assert property (halt_fire_w |-> kcnt_r == '0 ##1
    irq_o && status_o[ACS_ST_STOP] && (status_o[31:16] & $past(param_w)) == $past(param_w))
    else $error("Halt did not stop, merge mask and interrupt");

  stop_quiet_a: assert property (state_r == ACS_S_STOP |->
    !cmd_ready_o && !kern_valid_o && !dma_valid_o)
    else $error("Work started while stopped");

  notify_irq_a: assert property (nfire_w |=> irq_o && !status_o[ACS_ST_STOP] &&
    (status_o[31:16] & $past(nmask_r)) == $past(nmask_r))
    else $error("Notify did not merge mask and interrupt");

  notify_wait_a: assert property (npend_r && ncnt_r != '0 |=> !irq_o)
    else $error("Notify interrupt raised before older kernels finished");

  mask_sticky_a: assert property (!status_clr_i |=>
    ($past(status_o[31:16]) & ~status_o[31:16]) == 16'h0000)
    else $error("Status mask bit lost without a clear");

  conv_start_a: assert property (kern_raise_w && code_w == ACS_OP_CONV |=>
    kern_valid_o && kern_info_o.op == ACS_OP_CONV && kern_state_o == $past(state_tab_r))
    else $error("Convolution not launched with stored state");

  cov_halt_c: cover property (halt_fire_w ##1 irq_o);
  cov_notify_c: cover property (notify_take_w ##[1:20] nfire_w);
  cov_overlap_c: cover property (kern_hs_w ##[1:10] kern_hs_w);
  cov_dmaw_c: cover property (exec_w && op_dmaw_w && dma_pend_r ##[1:20] exec_done_w);

endmodule : acs_sequencer

// File: sim/acs_unit_model.sv
// Purpose: Behavioural kernel and DMA units facing the sequencer
// Assumes: Bench steers acceptance and completion of each unit
// Notes: Kernels finish in issue order, one per cycle while released

`timescale 1ns/10ps

module acs_unit_model (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic kern_valid_i,
  output logic kern_ready_o,
  output logic kern_done_o,
  input wire logic dma_valid_i,
  output logic dma_ready_o,
  output logic dma_done_o,
  input wire logic kern_go_i,
  input wire logic kern_fin_i,
  input wire logic dma_go_i,
  input wire logic dma_fin_i,
  output logic [7:0] launch_cnt_o
);
  logic [3:0] pend_r;
  logic dma_busy_r;
  logic klaunch;

  assign kern_ready_o = kern_go_i;
  assign dma_ready_o = dma_go_i && !dma_busy_r;
  assign klaunch = kern_valid_i && kern_ready_o;

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      pend_r <= 4'h0;
      kern_done_o <= 1'b0;
      dma_busy_r <= 1'b0;
      dma_done_o <= 1'b0;
      launch_cnt_o <= 8'h00;
    end else begin
      pend_r <= pend_r + 4'(klaunch) - 4'(kern_done_o);
      kern_done_o <= kern_fin_i && (pend_r > 4'(kern_done_o));
      dma_busy_r <= (dma_busy_r && !dma_done_o) || (dma_valid_i && dma_ready_o);
      dma_done_o <= dma_fin_i && dma_busy_r && !dma_done_o;
      launch_cnt_o <= launch_cnt_o + 8'(klaunch);
    end
  end
endmodule : acs_unit_model

// File: sim/acs_sequencer_bench.sv
// Purpose: Self-checking bench for the command sequencer
// Assumes: Unit model answers kernel and DMA requests
// Notes: Each scenario is one task

`timescale 1ns/10ps

module acs_sequencer_bench;
  import acs_pkg::*;
  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  acs_cmd_t cmd_i = '0;
  logic cmd_valid_i = 1'b0;
  logic status_clr_i = 1'b0;
  logic resume_i = 1'b0;
  logic kgo = 1'b1, kfin = 1'b0, dgo = 1'b1, dfin = 1'b0;
  logic cmd_ready_o, kern_valid_o, kern_ready_i, kern_done_i;
  logic dma_valid_o, dma_ready_i, dma_done_i, irq_o, bad_cmd_o;
  acs_kern_t kern_info_o;
  acs_regs_t kern_state_o;
  logic [1:0] blockdep_o;
  logic [31:0] status_o;
  logic [7:0] launches;
  int fails = 0, cmp_count = 0, irq_cnt = 0, bad_cnt = 0;

  always #2.5 core_clk_i = ~core_clk_i;

  always @(posedge core_clk_i) begin
    irq_cnt <= irq_cnt + int'(irq_o === 1'b1);
    bad_cnt <= bad_cnt + int'(bad_cmd_o === 1'b1);
  end

  acs_sequencer dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .cmd_i(cmd_i),
    .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .kern_valid_o(kern_valid_o),
    .kern_ready_i(kern_ready_i), .kern_info_o(kern_info_o), .kern_state_o(kern_state_o),
    .kern_done_i(kern_done_i), .dma_valid_o(dma_valid_o), .dma_ready_i(dma_ready_i),
    .dma_done_i(dma_done_i), .blockdep_o(blockdep_o), .status_o(status_o),
    .status_clr_i(status_clr_i), .resume_i(resume_i), .irq_o(irq_o), .bad_cmd_o(bad_cmd_o));

  acs_unit_model units (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .kern_valid_i(kern_valid_o),
    .kern_ready_o(kern_ready_i), .kern_done_o(kern_done_i), .dma_valid_i(dma_valid_o),
    .dma_ready_o(dma_ready_i), .dma_done_o(dma_done_i), .kern_go_i(kgo), .kern_fin_i(kfin),
    .dma_go_i(dgo), .dma_fin_i(dfin), .launch_cnt_o(launches));

  task end_sim;
    if (fails == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task send(input logic [15:0] w, input logic [15:0] p);
    int n;
    @(posedge core_clk_i);
    cmd_i <= {w, p};
    cmd_valid_i <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (cmd_ready_o !== 1'b1 && n < 300);
    cmd_valid_i <= 1'b0;
    check("take", 32'(n < 300), 32'h1);
  endtask : send

  task wait_ready;
    int n;
    n = 0;
    @(posedge core_clk_i);
    #1;
    while (cmd_ready_o !== 1'b1 && n < 300) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    check("ready", 32'(n < 300), 32'h1);
  endtask : wait_ready

  task hold(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : hold

  task t_state;
    send(16'h0105, 16'h0005);
    send({6'h00, ACS_OP_CONV}, 16'h0000);
    wait_ready;
    check("op", 32'(kern_info_o.op), 32'(ACS_OP_CONV));
    check("state", 32'(kern_state_o[5]), 32'h5);
    check("kbusy", 32'(status_o[ACS_ST_KBUSY]), 32'h1);
    send(16'h0105, 16'h0009);
    wait_ready;
    check("held", 32'(kern_state_o[5]), 32'h5);
  endtask : t_state

  task t_notify;
    send({6'h00, ACS_OP_NOTIFY}, 16'h00a5);
    send(16'h0105, 16'h0007);
    wait_ready;
    check("early irq", 32'(irq_cnt), 32'h0);
    check("npend", 32'(status_o[ACS_ST_NPEND]), 32'h1);
    @(posedge core_clk_i) kfin <= 1'b1;
    hold(6);
    check("irq", 32'(irq_cnt), 32'h1);
    check("mask", 32'(status_o[31:16]), 32'h00a5);
    check("run", 32'(status_o[ACS_ST_STOP]), 32'h0);
    check("kidle", 32'(status_o[ACS_ST_KBUSY]), 32'h0);
  endtask : t_notify

  task t_ops;
    logic [9:0] codes [3];
    codes = '{ACS_OP_DWCONV, ACS_OP_POOL, ACS_OP_ELEM};
    for (int i = 0; i < 3; i++) begin
      send({6'h00, codes[i]}, 16'(i + 1));
      wait_ready;
      check("op", 32'(kern_info_o.op), 32'(codes[i]));
      check("mode", 32'(kern_info_o.mode), 32'(i + 1));
      check("state", 32'(kern_state_o[5]), 32'h7);
    end
  endtask : t_ops

  task t_dep;
    logic [7:0] l0;
    @(posedge core_clk_i) kfin <= 1'b0;
    send({6'h00, ACS_OP_BLOCKDEP}, 16'h0000);
    wait_ready;
    check("dep", 32'(blockdep_o), 32'h0);
    l0 = launches;
    send({6'h00, ACS_OP_CONV}, 16'h0000);
    send({6'h00, ACS_OP_CONV}, 16'h0000);
    hold(10);
    check("overlap", 32'(launches), 32'(l0) + 1);
    check("blocked", 32'(cmd_ready_o), 32'h0);
    @(posedge core_clk_i) kfin <= 1'b1;
    wait_ready;
    check("second", 32'(launches), 32'(l0) + 2);
  endtask : t_dep

  task t_kwait;
    @(posedge core_clk_i) kfin <= 1'b0;
    send({6'h00, ACS_OP_CONV}, 16'h0000);
    send({6'h00, ACS_OP_KWAIT}, 16'h0001);
    wait_ready;
    check("kwait one", 32'(status_o[ACS_ST_KBUSY]), 32'h1);
    send({6'h00, ACS_OP_KWAIT}, 16'h0000);
    hold(8);
    check("kwait", 32'(cmd_ready_o), 32'h0);
    @(posedge core_clk_i) kfin <= 1'b1;
    wait_ready;
    check("kdone", 32'(status_o[ACS_ST_KBUSY]), 32'h0);
  endtask : t_kwait

  task t_dma;
    @(posedge core_clk_i) dgo <= 1'b0;
    send({6'h00, ACS_OP_DMAQ}, 16'h0000);
    hold(8);
    check("qstall", 32'(cmd_ready_o), 32'h0);
    check("dvalid", 32'(dma_valid_o), 32'h1);
    @(posedge core_clk_i) dgo <= 1'b1;
    wait_ready;
    check("dbusy", 32'(status_o[ACS_ST_DBUSY]), 32'h1);
    send({6'h00, ACS_OP_DMAW}, 16'h0000);
    hold(8);
    check("dwait", 32'(cmd_ready_o), 32'h0);
    @(posedge core_clk_i) dfin <= 1'b1;
    wait_ready;
    check("didle", 32'(status_o[ACS_ST_DBUSY]), 32'h0);
  endtask : t_dma

  task t_bad;
    send(16'h4000, 16'h0000);
    wait_ready;
    check("bad pulse", 32'(bad_cmd_o), 32'h1);
    hold(1);
    check("bad", 32'(bad_cnt), 32'h1);
  endtask : t_bad

  task t_halt;
    int i0;
    @(posedge core_clk_i) kfin <= 1'b0;
    send({6'h00, ACS_OP_CONV}, 16'h0000);
    i0 = irq_cnt;
    send({6'h00, ACS_OP_HALT}, 16'h0f00);
    hold(8);
    check("hwait", 32'(irq_cnt), 32'(i0));
    @(posedge core_clk_i) kfin <= 1'b1;
    hold(6);
    check("hirq", 32'(irq_cnt), 32'(i0 + 1));
    check("stop", 32'(status_o[ACS_ST_STOP]), 32'h1);
    check("hmask", 32'(status_o[31:16]), 32'h0fa5);
    hold(8);
    check("parked", 32'(cmd_ready_o), 32'h0);
    @(posedge core_clk_i) resume_i <= 1'b1;
    @(posedge core_clk_i) resume_i <= 1'b0;
    wait_ready;
    check("resumed", 32'(status_o[ACS_ST_STOP]), 32'h0);
    @(posedge core_clk_i) status_clr_i <= 1'b1;
    @(posedge core_clk_i) status_clr_i <= 1'b0;
    hold(2);
    check("clr", 32'(status_o[31:16]), 32'h0);
  endtask : t_halt

  initial begin
    #20000;
    fails++;
    end_sim;
  end

  initial begin
    repeat (4) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    hold(1);
    check("status", status_o, ACS_STATUS_RST);
    check("dep rst", 32'(blockdep_o), 32'(ACS_BLOCKDEP_RST));
    t_state;
    t_notify;
    t_ops;
    t_dep;
    t_kwait;
    t_dma;
    t_bad;
    t_halt;
    end_sim;
  end
endmodule : acs_sequencer_bench
